// ==== klac_map.svh ====
// Constants of the key-load and authentication command engine
//
// Function
// [R1] Any error during a command sets the summary error bit of primary status.
// [R2] Separate cause flags for key, access, checksum, frame, parity, collision, overflow.
// [R3] Key-from-EEPROM, code 0B: address low then high from FIFO, then run.
// [R4] Key-from-EEPROM starts on host request, ends after key reaches key buffer.
// [R5] Bad EEPROM key format: key buffer gets undefined value, key error set.
// [R6] Key-from-FIFO, code 19: twelve bytes LSB first, checked then copied.
// [R7] Key-from-FIFO starts on host request, ends after key reaches key buffer.
// [R8] Key-from-FIFO consumes all bytes even on bad format; key error set.
// [R9] Auth step one, code 0C: six FIFO bytes sent to the card.
// [R10] Auth step one keeps the card reply internal, not to host.
// [R11] Both auth steps follow transceive: transmit then receive.
// [R12] Auth step two, code 14: no arguments, device builds data, reply internal.
// [R13] Successful auth step two sets cipher-active bit; cipher then used.
// [R14] Failed auth step two clears cipher-active bit.
// [R15] Host never sets cipher-active bit; host may clear it.
// [R16] Host issues step two right after successful step one, matching key.
// [R17] Summary error bit is the OR of the cause flags.
`ifndef KLAC_MAP_SVH
`define KLAC_MAP_SVH
`define KLAC_CMD_IDLE 8'h00
`define KLAC_CMD_KEY_EEPROM 8'h0B
`define KLAC_CMD_KEY_FIFO 8'h19
`define KLAC_CMD_AUTH_ONE 8'h0C
`define KLAC_CMD_AUTH_TWO 8'h14
`define KLAC_EE_ARG_BYTES 4'h2
`define KLAC_KEY_BYTES 4'hC
`define KLAC_AUTH1_BYTES 4'h6
`define KLAC_ERR_KEY 0
`define KLAC_ERR_ACCESS 1
`define KLAC_ERR_OVERFLOW 2
`define KLAC_ERR_CHECKSUM 3
`define KLAC_ERR_FRAME 4
`define KLAC_ERR_PARITY 5
`define KLAC_ERR_COLLISION 6
`define KLAC_ERR_RESET 8'h00
`endif

// ==== klac_pkg.sv ====
// Types of the key-load and authentication command engine
`default_nettype none
package klac_pkg;
	typedef enum logic [6:0] {
		KLAC_IDLE = 7'h01,
		KLAC_ARGS = 7'h02,
		KLAC_EE_RD = 7'h04,
		KLAC_CHECK = 7'h08,
		KLAC_TX = 7'h10,
		KLAC_RX = 7'h20,
		KLAC_DONE = 7'h40
	} klac_state_t;
	typedef struct packed {
		klac_state_t state;
		logic [7:0] cmd;
		logic [3:0] cnt;
		logic [95:0] shift;
		logic [95:0] key;
		logic [15:0] ee_addr;
		logic [7:0] err;
		logic cipher;
		logic tx_valid;
		logic [7:0] tx_data;
		logic busy;
	} klac_regs_t;
endpackage
`default_nettype wire

// ==== klac_engine.sv ====
// Key-load and card-authentication command engine
`timescale 1ns/1ps
`default_nettype none
`include "klac_map.svh"
module klac_engine (
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	// Host command start and flag clears
	input wire logic CMD_START_I,
	input wire logic [7:0] CMD_CODE_I,
	input wire logic CIPHER_CLEAR_I,
	input wire logic ERR_CLEAR_I,
	// FIFO read side
	input wire logic FIFO_VALID_I,
	input wire logic [7:0] FIFO_DATA_I,
	output logic FIFO_POP_O,
	input wire logic FIFO_OVERFLOW_I,
	// EEPROM key fetch
	output logic EE_REQ_O,
	output logic [15:0] EE_ADDR_O,
	input wire logic EE_ACK_I,
	input wire logic [95:0] EE_DATA_I,
	input wire logic EE_ACCESS_ERR_I,
	// Card link transceiver
	output logic CARD_TX_VALID_O,
	output logic [7:0] CARD_TX_DATA_O,
	input wire logic CARD_TX_READY_I,
	input wire logic CARD_RX_DONE_I,
	input wire logic CARD_AUTH_OK_I,
	input wire logic CARD_CHECKSUM_ERR_I,
	input wire logic CARD_FRAME_ERR_I,
	input wire logic CARD_PARITY_ERR_I,
	input wire logic CARD_COLLISION_ERR_I,
	// Status
	output logic BUSY_O,
	output logic [95:0] KEY_BUFFER_O,
	output logic CIPHER_ACTIVE_O,
	output logic [7:0] ERROR_CAUSE_O,
	output logic PRIMARY_ERR_O
);
	import klac_pkg::*;

	klac_regs_t r_q;
	klac_regs_t r_d;

	// Each key byte must be a nibble and its complement
	function automatic logic key_ok(input logic [95:0] k);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < 12; i++) begin
			if (k[i*8+4 +: 4] != ~k[i*8 +: 4]) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction

	function automatic logic [3:0] arg_count(input logic [7:0] c);
		case (c)
			`KLAC_CMD_KEY_EEPROM: arg_count = `KLAC_EE_ARG_BYTES;
			`KLAC_CMD_KEY_FIFO: arg_count = `KLAC_KEY_BYTES;
			`KLAC_CMD_AUTH_ONE: arg_count = `KLAC_AUTH1_BYTES;
			default: arg_count = 4'h0;
		endcase
	endfunction

	logic known;
	logic pop;
	assign known = (CMD_CODE_I == `KLAC_CMD_KEY_EEPROM) ||
		(CMD_CODE_I == `KLAC_CMD_KEY_FIFO) ||
		(CMD_CODE_I == `KLAC_CMD_AUTH_ONE) ||
		(CMD_CODE_I == `KLAC_CMD_AUTH_TWO);
	assign pop = (r_q.state == KLAC_ARGS) && FIFO_VALID_I;

	always_comb begin
		r_d = r_q;
		// Error flags: events win over a same-cycle clear
		if (ERR_CLEAR_I) begin
			r_d.err = `KLAC_ERR_RESET;
		end
		if (FIFO_OVERFLOW_I) begin
			r_d.err[`KLAC_ERR_OVERFLOW] = 1'b1; // [R2]
		end
		// Host may only clear the cipher bit
		if (CIPHER_CLEAR_I) begin
			r_d.cipher = 1'b0; // [R15]
		end
		case (r_q.state)
			KLAC_IDLE: begin
				r_d.busy = 1'b0;
				if (CMD_START_I && known) begin // [R4] [R7]
					r_d.cmd = CMD_CODE_I;
					r_d.cnt = 4'h0;
					r_d.shift = '0;
					r_d.busy = 1'b1;
					if (CMD_CODE_I == `KLAC_CMD_AUTH_TWO) begin
						// No arguments, frame built internally
						r_d.state = KLAC_TX; // [R12]
					end else begin
						r_d.state = KLAC_ARGS;
					end
				end
			end
			KLAC_ARGS: begin
				if (pop) begin
					// Bytes arrive LSB first
					r_d.shift[r_q.cnt*8 +: 8] = FIFO_DATA_I; // [R3] [R6] [R9]
					r_d.cnt = r_q.cnt + 4'h1;
					if (r_q.cnt + 4'h1 == arg_count(r_q.cmd)) begin
						r_d.cnt = 4'h0;
						case (r_q.cmd)
							`KLAC_CMD_KEY_EEPROM: begin
								r_d.ee_addr = {FIFO_DATA_I,
									r_q.shift[7:0]}; // [R3]
								r_d.state = KLAC_EE_RD;
							end
							`KLAC_CMD_KEY_FIFO: r_d.state = KLAC_CHECK; // [R8]
							default: r_d.state = KLAC_TX; // [R11]
						endcase
					end
				end
			end
			KLAC_EE_RD: begin
				if (EE_ACK_I) begin
					r_d.shift = EE_DATA_I;
					if (EE_ACCESS_ERR_I) begin
						r_d.err[`KLAC_ERR_ACCESS] = 1'b1; // [R2]
					end
					r_d.state = KLAC_CHECK;
				end
			end
			KLAC_CHECK: begin
				// Undefined on bad format: raw bytes are loaded as-is
				r_d.key = r_q.shift; // [R5] [R8]
				if (!key_ok(r_q.shift)) begin
					r_d.err[`KLAC_ERR_KEY] = 1'b1; // [R5] [R8] [R2]
				end
				r_d.state = KLAC_DONE; // [R4] [R7]
			end
			KLAC_TX: begin
				r_d.tx_valid = 1'b1;
				if (r_q.cmd == `KLAC_CMD_AUTH_ONE) begin
					r_d.tx_data = r_q.shift[r_q.cnt*8 +: 8]; // [R9]
				end else begin
					// Step two token from the key buffer
					r_d.tx_data = r_q.key[r_q.cnt*8 +: 8]; // [R12]
				end
				if (r_q.tx_valid && CARD_TX_READY_I) begin
					r_d.cnt = r_q.cnt + 4'h1;
					if (r_q.cnt + 4'h1 == `KLAC_AUTH1_BYTES) begin
						r_d.tx_valid = 1'b0;
						r_d.state = KLAC_RX; // [R11]
					end else begin
						r_d.tx_data = (r_q.cmd == `KLAC_CMD_AUTH_ONE) ?
							r_q.shift[(r_q.cnt+4'h1)*8 +: 8] :
							r_q.key[(r_q.cnt+4'h1)*8 +: 8];
					end
				end
			end
			KLAC_RX: begin
				// Reply is consumed here and never reaches the FIFO
				if (CARD_RX_DONE_I) begin // [R10] [R12]
					if (CARD_CHECKSUM_ERR_I) begin
						r_d.err[`KLAC_ERR_CHECKSUM] = 1'b1; // [R2]
					end
					if (CARD_FRAME_ERR_I) begin
						r_d.err[`KLAC_ERR_FRAME] = 1'b1; // [R2]
					end
					if (CARD_PARITY_ERR_I) begin
						r_d.err[`KLAC_ERR_PARITY] = 1'b1; // [R2]
					end
					if (CARD_COLLISION_ERR_I) begin
						r_d.err[`KLAC_ERR_COLLISION] = 1'b1; // [R2]
					end
					if (r_q.cmd == `KLAC_CMD_AUTH_TWO) begin
						// Success outranks a same-cycle host clear
						r_d.cipher = CARD_AUTH_OK_I; // [R13] [R14]
					end
					r_d.state = KLAC_DONE;
				end
			end
			KLAC_DONE: begin
				r_d.busy = 1'b0;
				r_d.cnt = 4'h0;
				r_d.state = KLAC_IDLE;
			end
			default: r_d.state = KLAC_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			r_q <= '0;
			r_q.state <= KLAC_IDLE;
			r_q.cmd <= `KLAC_CMD_IDLE;
			r_q.err <= `KLAC_ERR_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	assign FIFO_POP_O = pop;
	assign EE_REQ_O = (r_q.state == KLAC_EE_RD);
	assign EE_ADDR_O = r_q.ee_addr;
	assign CARD_TX_VALID_O = r_q.tx_valid;
	assign CARD_TX_DATA_O = r_q.tx_data;
	assign BUSY_O = r_q.busy;
	assign KEY_BUFFER_O = r_q.key;
	assign CIPHER_ACTIVE_O = r_q.cipher; // [R13]
	assign ERROR_CAUSE_O = r_q.err;
	assign PRIMARY_ERR_O = |r_q.err; // [R1] [R17]
endmodule
`default_nettype wire

// ==== klac_monitor.sv ====
// Port checker for the key-load and authentication engine
`timescale 1ns/1ps
`default_nettype none
module klac_monitor (
	input wire logic SYS_CLK_I, RST_N_I, CMD_START_I,
	input wire logic [7:0] CMD_CODE_I,
	input wire logic FIFO_VALID_I, FIFO_POP_O, FIFO_OVERFLOW_I,
	input wire logic EE_REQ_O, CARD_TX_VALID_O, CARD_RX_DONE_I,
	input wire logic CARD_AUTH_OK_I, BUSY_O, CIPHER_ACTIVE_O,
	input wire logic [7:0] ERROR_CAUSE_O,
	input wire logic PRIMARY_ERR_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);
	property p_sum; PRIMARY_ERR_O == |ERROR_CAUSE_O; endproperty
	property p_rsv; ERROR_CAUSE_O[7] == 1'h0; endproperty
	property p_ovf; FIFO_OVERFLOW_I |=> ERROR_CAUSE_O[2]; endproperty
	property p_cset;
		$rose(CIPHER_ACTIVE_O) |-> $past(CARD_RX_DONE_I) && $past(CARD_AUTH_OK_I);
	endproperty
	property p_start;
		CMD_START_I && !BUSY_O && CMD_CODE_I inside {8'h0B, 8'h19, 8'h0C, 8'h14}
			|=> BUSY_O;
	endproperty
	property p_pop; FIFO_POP_O |-> FIFO_VALID_I && BUSY_O; endproperty
	property p_tx; CARD_TX_VALID_O |-> BUSY_O && !EE_REQ_O; endproperty
	property p_ee; EE_REQ_O |-> BUSY_O && !FIFO_POP_O; endproperty
	a_sum: assert property (p_sum) else $error("summary bit");
	a_rsv: assert property (p_rsv) else $error("spare bit");
	a_ovf: assert property (p_ovf) else $error("overflow flag");
	a_cset: assert property (p_cset) else $error("cipher set");
	a_start: assert property (p_start) else $error("no start");
	a_pop: assert property (p_pop) else $error("bad pop");
	a_tx: assert property (p_tx) else $error("idle send");
	a_ee: assert property (p_ee) else $error("idle fetch");
	c_busy: cover property ($rose(BUSY_O));
	c_cipher: cover property ($rose(CIPHER_ACTIVE_O));
	c_err: cover property ($rose(PRIMARY_ERR_O));
endmodule
`default_nettype wire

// ==== klac_partner.sv ====
// Far side model: host FIFO, key EEPROM and card transceiver
`timescale 1ns/1ps
`default_nettype none
module klac_partner (
	input wire logic clk_i, rst_n_i, pop_i, ee_req_i, tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic valid_o, ee_ack_o, tx_ready_o, rx_done_o,
	output logic [7:0] data_o,
	output logic [95:0] ee_data_o
);
	logic [7:0] q[$];
	logic [7:0] seen[$];
	logic [95:0] ee_key = '0;
	int sent = 0;
	task push(input logic [7:0] b);
		q.push_back(b);
	endtask
	initial {valid_o, ee_ack_o, tx_ready_o, rx_done_o, data_o, ee_data_o} = '0;
	always @(posedge clk_i) begin
		if (pop_i && q.size() != 0)
			void'(q.pop_front());
		if (tx_valid_i && tx_ready_o) begin
			sent++;
			seen.push_back(tx_data_i);
		end
	end
	// Released lines invert their data every cycle, so a stale copy never stays two cycles
	always @(negedge clk_i) begin
		valid_o <= q.size() != 0;
		data_o <= q.size() != 0 ? q[0] : ~data_o;
		ee_ack_o <= ee_req_i && !ee_ack_o;
		ee_data_o <= ee_req_i ? ee_key : ~ee_data_o;
		// Ready alternates so every frame meets stalls
		tx_ready_o <= !tx_ready_o && rst_n_i;
		rx_done_o <= sent == 6;
		if (sent == 6 || !rst_n_i)
			sent = 0;
	end
endmodule
`default_nettype wire

// ==== klac_engine_bench.sv ====
// Self-checking bench of the key-load and authentication engine
`timescale 1ns/1ps
`default_nettype none
module klac_engine_bench;
	logic SYS_CLK_I = 0, RST_N_I = 0, CMD_START_I = 0, CIPHER_CLEAR_I = 0;
	logic ERR_CLEAR_I = 0, FIFO_OVERFLOW_I = 0, EE_ACCESS_ERR_I = 0;
	logic CARD_AUTH_OK_I = 0, CARD_CHECKSUM_ERR_I = 0, CARD_FRAME_ERR_I = 0;
	logic CARD_PARITY_ERR_I = 0, CARD_COLLISION_ERR_I = 0;
	logic FIFO_VALID_I, FIFO_POP_O, EE_REQ_O, EE_ACK_I, CARD_TX_VALID_O;
	logic CARD_TX_READY_I, CARD_RX_DONE_I, BUSY_O, CIPHER_ACTIVE_O;
	logic PRIMARY_ERR_O;
	logic [7:0] CMD_CODE_I = '0, FIFO_DATA_I, CARD_TX_DATA_O, ERROR_CAUSE_O;
	logic [15:0] EE_ADDR_O;
	logic [95:0] EE_DATA_I, KEY_BUFFER_O;
	int miscompares = 0, checks_done = 0;
	always #2.5 SYS_CLK_I = ~SYS_CLK_I;
	klac_engine klac_engine_i (.SYS_CLK_I, .RST_N_I, .CMD_START_I, .CMD_CODE_I,
		.CIPHER_CLEAR_I, .ERR_CLEAR_I, .FIFO_VALID_I, .FIFO_DATA_I, .FIFO_POP_O,
		.FIFO_OVERFLOW_I, .EE_REQ_O, .EE_ADDR_O, .EE_ACK_I, .EE_DATA_I,
		.EE_ACCESS_ERR_I, .CARD_TX_VALID_O, .CARD_TX_DATA_O, .CARD_TX_READY_I,
		.CARD_RX_DONE_I, .CARD_AUTH_OK_I, .CARD_CHECKSUM_ERR_I, .CARD_FRAME_ERR_I,
		.CARD_PARITY_ERR_I, .CARD_COLLISION_ERR_I, .BUSY_O, .KEY_BUFFER_O,
		.CIPHER_ACTIVE_O, .ERROR_CAUSE_O, .PRIMARY_ERR_O);
	klac_partner klac_partner_i (.clk_i(SYS_CLK_I), .rst_n_i(RST_N_I),
		.pop_i(FIFO_POP_O), .ee_req_i(EE_REQ_O), .tx_valid_i(CARD_TX_VALID_O),
		.tx_data_i(CARD_TX_DATA_O), .valid_o(FIFO_VALID_I), .ee_ack_o(EE_ACK_I),
		.tx_ready_o(CARD_TX_READY_I), .rx_done_o(CARD_RX_DONE_I),
		.data_o(FIFO_DATA_I), .ee_data_o(EE_DATA_I));
	task chk(input logic [95:0] got, input logic [95:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task run(input logic [7:0] code);
		int n;
		@(negedge SYS_CLK_I);
		CMD_CODE_I = code;
		CMD_START_I = 1;
		@(negedge SYS_CLK_I);
		CMD_START_I = 0;
		chk(BUSY_O, code != 8'h55);
		for (n = 0; BUSY_O && n < 400; n++)
			@(negedge SYS_CLK_I);
		if (n == 400) begin
			miscompares++;
			end_of_test;
		end
	endtask
	// Clearing both at once also proves the host clear path
	task pulse_clear;
		ERR_CLEAR_I = 1;
		CIPHER_CLEAR_I = 1;
		@(negedge SYS_CLK_I);
		{ERR_CLEAR_I, CIPHER_CLEAR_I} = 2'h0;
		@(negedge SYS_CLK_I);
		chk({CIPHER_ACTIVE_O, PRIMARY_ERR_O, ERROR_CAUSE_O}, 0);
	endtask
	task t_fifo_key(input logic bad);
		logic [95:0] k;
		for (int i = 0; i < 12; i++) begin
			k[8*i+:8] = bad ? 8'h00 : {~i[3:0], i[3:0]};
			klac_partner_i.push(k[8*i+:8]);
		end
		run(8'h19);
		chk(klac_partner_i.q.size(), 0);
		if (!bad)
			chk(KEY_BUFFER_O, k);
		chk({PRIMARY_ERR_O, ERROR_CAUSE_O}, {bad, 7'h0, bad});
		$display("fifo key %0d done", bad);
	endtask
	task t_ee_key(input logic bad);
		klac_partner_i.ee_key = bad ? '0 : {12{8'hA5}};
		klac_partner_i.push(8'h34);
		klac_partner_i.push(8'h12);
		EE_ACCESS_ERR_I = bad;
		run(8'h0B);
		EE_ACCESS_ERR_I = 0;
		chk(EE_ADDR_O, 16'h1234);
		if (!bad)
			chk(KEY_BUFFER_O, {12{8'hA5}});
		chk(ERROR_CAUSE_O, {6'h0, bad, bad});
		$display("eeprom key %0d done", bad);
	endtask
	task t_auth(input logic [7:0] code, input logic ok, input logic [47:0] exp);
		klac_partner_i.seen.delete();
		CARD_AUTH_OK_I = ok;
		run(code);
		for (int i = 0; i < 6; i++)
			chk(klac_partner_i.seen[i], exp[8*i+:8]);
		chk({klac_partner_i.q.size(), CIPHER_ACTIVE_O}, code == 8'h14 && ok);
		$display("auth %h ok %0d done", code, ok);
	endtask
	initial begin
		repeat (20) @(negedge SYS_CLK_I);
		RST_N_I = 1;
		chk({BUSY_O, CIPHER_ACTIVE_O, ERROR_CAUSE_O, KEY_BUFFER_O}, 0);
		t_fifo_key(1'h1);
		pulse_clear;
		t_fifo_key(1'h0);
		t_ee_key(1'h1);
		pulse_clear;
		t_ee_key(1'h0);
		for (int i = 0; i < 6; i++)
			klac_partner_i.push(8'h60 + 8'(i));
		t_auth(8'h0C, 1'h1, 48'h656463626160);
		// Step two follows step one at once, key buffer matching
		t_auth(8'h14, 1'h1, {6{8'hA5}});
		pulse_clear;
		t_auth(8'h14, 1'h1, {6{8'hA5}});
		{CARD_CHECKSUM_ERR_I, CARD_FRAME_ERR_I} = 2'h3;
		{CARD_PARITY_ERR_I, CARD_COLLISION_ERR_I} = 2'h3;
		t_auth(8'h14, 1'h0, {6{8'hA5}});
		{CARD_CHECKSUM_ERR_I, CARD_FRAME_ERR_I} = 2'h0;
		{CARD_PARITY_ERR_I, CARD_COLLISION_ERR_I} = 2'h0;
		FIFO_OVERFLOW_I = 1;
		@(negedge SYS_CLK_I);
		FIFO_OVERFLOW_I = 0;
		chk({PRIMARY_ERR_O, ERROR_CAUSE_O}, 9'h17C);
		run(8'h55);
		$display("errors and refusal done");
		end_of_test;
	end
endmodule
bind klac_engine klac_monitor klac_monitor_i (.SYS_CLK_I, .RST_N_I,
	.CMD_START_I, .CMD_CODE_I, .FIFO_VALID_I, .FIFO_POP_O, .FIFO_OVERFLOW_I,
	.EE_REQ_O, .CARD_TX_VALID_O, .CARD_RX_DONE_I, .CARD_AUTH_OK_I, .BUSY_O,
	.CIPHER_ACTIVE_O, .ERROR_CAUSE_O, .PRIMARY_ERR_O);
`default_nettype wire
